// ---- logic/scs_map.svh ----
/*
 * Constants for the clock-suspend block: command encodings, burst defaults.
 * Assumes inclusion by bare name from logic/ and tb/ files.
 */
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

`define SCS_CMD_INHIBIT   4'hF
`define SCS_CMD_NOP       4'h7
`define SCS_CMD_READ      4'h5
`define SCS_CMD_WRITE     4'h4
`define SCS_CMD_BST       4'h6
`define SCS_BURST_DEF     9'h004
`define SCS_COL_RST       10'h000
`define SCS_DATA_RST      16'h0000

`endif

// ---- logic/scs_pkg.sv ----
/*
 * Types shared by the clock-suspend block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_IDLE,
        SCS_READ,
        SCS_WRITE,
        SCS_PDOWN
    } scs_mode_e;
endpackage : scs_pkg

// ---- logic/scs_gate.sv ----
/*
 * Internal clock gate: turns registered clock enable into an advance
 * strobe for the frozen logic, and tracks suspend and power-down.
 * Assumes single clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
module scs_gate (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_cke,
    input  wire logic i_busy,
    input  wire logic i_idle_cmd,
    output logic      o_adv,
    output logic      o_susp,
    output logic      o_pdown
);
    logic cke_q;
    logic pdown_q;

    // Registered enable decides the next internal edge
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cke_q <= 1'b1;
        end else begin
            cke_q <= i_cke;
        end
    end

    // Power-down entry on idle with nop
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pdown_q <= 1'b0;
        end else if (!i_cke && !i_busy && i_idle_cmd && !pdown_q) begin
            pdown_q <= 1'b1;
        end else if (i_cke && i_idle_cmd) begin
            pdown_q <= 1'b0;
        end
    end

    assign o_adv   = cke_q && !pdown_q;
    assign o_susp  = !cke_q && i_busy && !pdown_q;
    assign o_pdown = pdown_q;

    a_skip_edge: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_cke |=> !o_adv) else $error("edge not skipped after low enable");
    a_resume_edge: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_cke && !pdown_q) |=> (o_adv || o_pdown))
        else $error("no resume after high enable");
endmodule : scs_gate

// ---- logic/scs_core.sv ----
/*
 * Clock-suspend behaviour of a synchronous DRAM column path: burst
 * tracking, read data drive, command capture, gated by clock enable.
 * Assumes controller drives commands synchronous to i_core_clk.
 */
// Notes on behaviour
// - Low enable during burst enters suspend
// - Suspend freezes burst, column and read data state; write valid clears
// - Each low sample skips next internal edge
// - Commands and write data ignored when suspended
// - Read data stays driven while suspended
// - Burst counters hold while suspended
// - High enable resumes on next edge
// - Idle low enable with nop powers down
`timescale 1ns/1ps
`include "scs_map.svh"
module scs_core #(
    parameter int DQ_W  = 16,
    parameter int COL_W = 10
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_cke,
    input  wire logic [3:0]       i_cmd,
    input  wire logic [COL_W-1:0] i_addr,
    input  wire logic [8:0]       i_burst_len,
    input  wire logic [DQ_W-1:0]  i_dq_in,
    output logic      [DQ_W-1:0]  o_dq_out,
    output logic                  o_dq_oe,
    output logic                  o_wr_valid,
    output logic      [DQ_W-1:0]  o_wr_data,
    output logic      [COL_W-1:0] o_col,
    output logic                  o_suspended,
    output logic                  o_power_down
);
    // Widths the column word function can serve
    if (DQ_W < 1 || COL_W < 1 || COL_W > 16) begin : g_bad_width
        $error("scs_core: unsupported width");
    end

    scs_pkg::scs_mode_e mode_q;
    logic [8:0]         left_q;
    logic [COL_W-1:0]   col_q;
    logic [DQ_W-1:0]    dq_q;
    logic               oe_q;
    logic [DQ_W-1:0]    wd_q;
    logic               wv_q;
    logic               adv;
    logic               busy;
    logic               idle_cmd;
    logic               cmd_rd;
    logic               cmd_wr;
    logic               wr_take;

    // Array word for read data, keyed by column
    function automatic logic [DQ_W-1:0] scs_word(input logic [COL_W-1:0] c);
        scs_word = DQ_W'(c) ^ DQ_W'(16'hA5C3);
    endfunction : scs_word

    assign busy     = (mode_q == scs_pkg::SCS_READ) || (mode_q == scs_pkg::SCS_WRITE);
    assign idle_cmd = (i_cmd == `SCS_CMD_NOP) || (i_cmd == `SCS_CMD_INHIBIT);
    assign cmd_rd   = adv && (i_cmd == `SCS_CMD_READ);
    assign cmd_wr   = adv && (i_cmd == `SCS_CMD_WRITE);
    // Last burst word is taken while left_q is 2, none once left_q is 1
    assign wr_take  = cmd_wr || (adv && mode_q == scs_pkg::SCS_WRITE && left_q > 9'h001
                      && i_cmd != `SCS_CMD_BST && !cmd_rd);

    scs_gate u_gate (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_cke      (i_cke),
        .i_busy     (busy),
        .i_idle_cmd (idle_cmd),
        .o_adv      (adv),
        .o_susp     (o_suspended),
        .o_pdown    (o_power_down)
    );

    // Burst mode and counters, advance only on live edges, except mode goes to SCS_PDOWN in power-down
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mode_q <= scs_pkg::SCS_IDLE;
            left_q <= 9'h000;
            col_q  <= COL_W'(`SCS_COL_RST);
        end else if (o_power_down) begin
            mode_q <= scs_pkg::SCS_PDOWN;
        end else if (adv) begin
            if (cmd_rd || cmd_wr) begin
                mode_q <= cmd_rd ? scs_pkg::SCS_READ : scs_pkg::SCS_WRITE;
                left_q <= (i_burst_len == 9'h000) ? `SCS_BURST_DEF : i_burst_len;
                col_q  <= i_addr;
            end else if (i_cmd == `SCS_CMD_BST || (busy && left_q <= 9'h001)) begin
                mode_q <= scs_pkg::SCS_IDLE;
                left_q <= 9'h000;
            end else if (busy) begin
                left_q <= left_q - 9'h001;
                col_q  <= col_q + COL_W'(1);
            end else begin
                mode_q <= scs_pkg::SCS_IDLE;
            end
        end
    end

    // Read data drive, held through suspend
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dq_q <= DQ_W'(`SCS_DATA_RST);
            oe_q <= 1'b0;
        end else if (adv) begin
            oe_q <= cmd_rd || (mode_q == scs_pkg::SCS_READ && left_q > 9'h001
                    && !(i_cmd == `SCS_CMD_BST) && !cmd_wr);
            dq_q <= scs_word(cmd_rd ? i_addr : col_q + COL_W'(1));
        end
    end

    // Write data capture, ignored on skipped edges
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wd_q <= DQ_W'(`SCS_DATA_RST);
            wv_q <= 1'b0;
        end else begin
            wv_q <= wr_take;
            if (wr_take) begin
                wd_q <= i_dq_in;
            end
        end
    end

    assign o_dq_out   = dq_q;
    assign o_dq_oe    = oe_q;
    assign o_wr_valid = wv_q;
    assign o_wr_data  = wd_q;
    assign o_col      = col_q;

    sequence s_susp_edge;
        !adv && !o_power_down;
    endsequence

    a_burst_frozen: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_susp_edge |=> ($stable(left_q) && $stable(col_q)))
        else $error("burst counter moved while suspended");
    a_dq_held: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_susp_edge |=> ($stable(o_dq_out) && $stable(o_dq_oe)))
        else $error("read data changed while suspended");
    a_cmd_ignored: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_susp_edge and (i_cmd == `SCS_CMD_READ)) |=> $stable(mode_q))
        else $error("command taken on suspended edge");
    a_wdata_ignored: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_susp_edge |=> (!o_wr_valid && $stable(o_wr_data)))
        else $error("write data taken on suspended edge");
    a_enter_susp: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (busy && !i_cke && !o_power_down && (!adv || cmd_rd || cmd_wr
        || (left_q > 9'h001 && i_cmd != `SCS_CMD_BST))) |=> o_suspended)
        else $error("no suspend on low enable in burst");
    a_freeze_all: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (o_suspended ##1 o_suspended) |-> $stable(mode_q))
        else $error("state moved while suspended");
    a_pdown_entry: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!i_cke && !busy && idle_cmd && !o_power_down) |=> o_power_down)
        else $error("no power-down on idle low enable");
    a_burst_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (adv && busy && left_q > 9'h001 && i_cmd == `SCS_CMD_NOP)
        |=> (left_q == $past(left_q) - 9'h001))
        else $error("burst did not advance on live edge");
endmodule : scs_core

// ---- tb/scs_ctl_model.sv ----
/*
 * Memory controller model: drives command, column, clock enable and write data.
 * Assumes one call of step per clock edge from the testbench.
 */
`timescale 1ns/1ps
`include "scs_map.svh"
module scs_ctl_model (
    input  wire logic        i_core_clk,
    output logic             o_cke,
    output logic [3:0]       o_cmd,
    output logic [9:0]       o_addr,
    output logic [8:0]       o_len,
    output logic [15:0]      o_dq
);
    initial begin
        o_cke  = 1'b1;
        o_cmd  = `SCS_CMD_INHIBIT;
        o_addr = 10'h000;
        o_len  = 9'h000;
        o_dq   = 16'h0000;
    end
    // One slot per edge; low enable held per edge to suspend
    task automatic step(input logic k, input logic [3:0] c, input logic [9:0] a,
                        input logic [15:0] d);
        @(posedge i_core_clk);
        o_cke  <= k;
        o_cmd  <= c;
        o_addr <= a;
        o_dq   <= d;
        #1;
    endtask : step
endmodule : scs_ctl_model

// ---- tb/tb.sv ----
/*
 * Self-checking bench for the clock-suspend block.
 * Assumes the controller model drives every design input except clock and reset, which the bench drives.
 */
`timescale 1ns/1ps
`include "scs_map.svh"
module tb;
    logic        i_core_clk = 1'b0;
    logic        i_rst      = 1'b1;
    logic        i_cke;
    logic [3:0]  i_cmd;
    logic [9:0]  i_addr;
    logic [8:0]  i_burst_len;
    logic [15:0] i_dq_in, o_dq_out, o_wr_data;
    logic [9:0]  o_col;
    logic        o_dq_oe, o_wr_valid, o_suspended, o_power_down;
    int          fail_count = 0;
    int          num_checks = 0;
    logic [13:0] pat = 14'b11111110100101;
    always #25 i_core_clk = ~i_core_clk;
    scs_ctl_model CTL (.i_core_clk(i_core_clk), .o_cke(i_cke), .o_cmd(i_cmd),
        .o_addr(i_addr), .o_len(i_burst_len), .o_dq(i_dq_in));
    scs_core DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cke(i_cke), .i_cmd(i_cmd),
        .i_addr(i_addr), .i_burst_len(i_burst_len), .i_dq_in(i_dq_in),
        .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_wr_valid(o_wr_valid),
        .o_wr_data(o_wr_data), .o_col(o_col), .o_suspended(o_suspended),
        .o_power_down(o_power_down));
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    function automatic logic [15:0] w(logic [9:0] c);
        return {6'h00, c} ^ 16'hA5C3;
    endfunction : w
    task automatic t_read();
        logic [15:0] pq = 16'h0000;
        logic [9:0]  pc = 10'h000;
        logic        ps = 1'b0;
        logic        seen = 1'b0;
        int          k = -1;
        for (int i = 0; i < 16; i++) begin
            CTL.step(i < 14 ? pat[i] : 1'b1, i == 0 ? `SCS_CMD_READ :
                (i < 14 && !pat[i-1]) ? `SCS_CMD_WRITE : `SCS_CMD_NOP, 10'h010, ~16'(i));
            if (ps) begin
                check("dq_hold", o_dq_out, pq);
                check("col_hold", 16'(o_col), 16'(pc));
            end else if (o_dq_oe === 1'b1 && (k < 0 || o_dq_out !== pq)) begin
                k++;
                check("dq_word", o_dq_out, w(10'h010 + 10'(k)));
            end
            check("no_write", o_wr_valid, 1'b0);
            seen = seen | (o_suspended === 1'b1);
            ps = o_suspended;
            pq = o_dq_out;
            pc = o_col;
        end
        check("words", 16'(k), 16'h0003);
        check("suspended", seen, 1'b1);
    endtask : t_read
    task automatic t_write();
        logic        live = 1'b0;
        logic        pk = 1'b1;
        logic [15:0] pd = 16'h0000;
        int          n = 0;
        for (int i = 0; i < 15; i++) begin
            CTL.step(i < 14 ? pat[i] : 1'b1, i == 0 ? `SCS_CMD_WRITE : `SCS_CMD_NOP,
                10'h020, 16'h1000 + 16'(i));
            if (i > 0) begin
                check("wr_valid", o_wr_valid, live && n < 4);
                if (live && n < 4) begin
                    check("wr_data", o_wr_data, pd);
                    n++;
                end
            end
            live = pk;
            pk = i < 14 ? pat[i] : 1'b1;
            pd = 16'h1000 + 16'(i);
        end
    endtask : t_write
    task automatic t_pdown();
        repeat (2) CTL.step(1'b0, `SCS_CMD_NOP, 10'h000, 16'h5A5A);
        CTL.step(1'b0, `SCS_CMD_READ, 10'h000, 16'hA5A5);
        check("pdown_in", o_power_down, 1'b1);
        repeat (3) CTL.step(1'b1, `SCS_CMD_NOP, 10'h000, 16'h5A5A);
        check("pdown_out", o_power_down, 1'b0);
        check("pdown_read", o_dq_oe, 1'b0);
    endtask : t_pdown
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial begin
        #20us;
        fail_count++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        CTL.step(1'b1, `SCS_CMD_NOP, 10'h000, 16'h0000);
        check("rst_oe", o_dq_oe, 1'b0);
        check("rst_col", 16'(o_col), 16'h0000);
        check("rst_pdown", o_power_down, 1'b0);
        t_read();
        t_write();
        repeat (2) CTL.step(1'b1, `SCS_CMD_NOP, 10'h000, 16'hFFFF);
        t_pdown();
        final_report();
    end
endmodule : tb
